// ==== hdl/mcap_top.sv ====
// Control unit for the module control and alarm pins, with an APB register port.
// Assumes status inputs are synchronous to clk; the MDIO engine and laser drivers sit outside.
//
// Function
// - Transmit-off request high turns the optical transmit output off.
// - Transmit-off request low turns the optical transmit output on.
// - Transmitter is off within 100 us of the request rising.
// - Transmitter is back on within 25 s of the request falling.
// - Low-power request high holds the module in low-power mode.
// - Low-power request low runs initialization into high-power operation.
// - Management access keeps working while in low-power mode.
// - Module reset input low holds the module in reset.
// - Module reset input high starts power-up initialization.
// - Initialization after reset lasts at least 19 s, at most 150 s.
// - Signal-lost output is high while received power is too low.
// - Signal-lost asserts between 0.5 us and 400 us after power loss.
// - Signal-lost deasserts between 0.5 us and 400 us after recovery.
// - Presence output is pulled low inside an inserted module.
// - Host drives port address pins; bit 0 is the address LSB.
// - Management port uses clause 45 MDIO framing and addressing.
// - Monitor clock runs at one forty-eighth of the symbol rate.
// - Transmit-off request disables all lanes together.
// - Module state is reported one-hot, exactly one bit set.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module mcap_top
    import mcap_pkg::*;
#(
    parameter int LANES = 4,
    parameter int PORT_ADDR_W = 5,
    parameter logic [TIMER_W-1:0] INIT_MIN_CYCLES = TIMER_W'(INIT_MIN_CYC),
    parameter logic [TIMER_W-1:0] INIT_MAX_CYCLES = TIMER_W'(INIT_MAX_CYC),
    parameter logic [TIMER_W-1:0] TX_ON_MAX_CYCLES = TIMER_W'(TX_ON_MAX_CYC),
    parameter logic [TIMER_W-1:0] TX_OFF_MAX_CYCLES = TIMER_W'(TX_OFF_MAX_CYC)
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host control pins
    input wire logic transmit_off_request,
    input wire logic low_power_request,
    input wire logic module_reset_low,
    input wire logic [PORT_ADDR_W-1:0] port_address_pins,
    // Internal status from the optics and DSP
    input wire logic init_done,
    input wire logic power_up_done,
    input wire logic laser_locked,
    input wire logic rx_power_low,
    input wire logic symbol_tick,
    // Alarm, presence and monitor clock pins
    output logic receive_signal_lost,
    output logic presence_absent_out,
    output logic transmit_monitor_clock,
    // Internal controls
    output logic [LANES-1:0] transmit_enable,
    output logic low_power_mode,
    output logic [PORT_ADDR_W-1:0] mdio_port_address,
    output logic [8:0] module_state
);

    if (LANES < 1 || PORT_ADDR_W != 5 || INIT_MIN_CYCLES == '0 || INIT_MIN_CYCLES > INIT_MAX_CYCLES
        || TX_ON_MAX_CYCLES == '0 || TX_OFF_MAX_CYCLES < TIMER_W'(3))
    begin : g_bad_params
        $error("mcap_top: parameters out of range");
    end

    function automatic logic is_addr(input logic [11:0] addr, input logic [11:0] ofs);
        is_addr = (addr[11:2] == ofs[11:2]);
    endfunction

    // Reset release through two flops
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Pin synchronisers; first stage feeds only the second
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [PORT_ADDR_W-1:0] addr_meta;
    logic [PORT_ADDR_W-1:0] addr_sync;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
            addr_meta <= '0;
            addr_sync <= '0;
        end
        else
        begin
            pin_meta <= {module_reset_low, low_power_request, transmit_off_request};
            pin_sync <= pin_meta;
            addr_meta <= port_address_pins;
            addr_sync <= addr_meta;
        end
    end

    logic txd_pin;
    logic lp_pin;
    logic rst_pin_low;
    assign txd_pin = pin_sync[0];
    assign lp_pin = pin_sync[1];
    assign rst_pin_low = !pin_sync[2];

    // Software control bits
    logic soft_lp;
    logic soft_txd;
    logic monclk_en;
    logic soft_rst;
    logic apb_write;
    logic apb_setup;
    assign apb_write = psel && penable && pwrite;
    assign apb_setup = psel && !penable;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {soft_lp, soft_txd, monclk_en} <= CTRL_RESET;
            soft_rst <= 1'b0;
        end
        else
        begin
            // Soft reset lasts one cycle; writing zero does nothing
            soft_rst <= apb_write && is_addr(paddr, CTRL_OFS) && pwdata[CTRL_SOFT_RST_BIT];
            if (apb_write && is_addr(paddr, CTRL_OFS))
            begin
                soft_lp <= pwdata[CTRL_SOFT_LP_BIT];
                soft_txd <= pwdata[CTRL_SOFT_TXD_BIT];
                monclk_en <= pwdata[CTRL_MONCLK_EN_BIT];
            end
        end
    end

    logic hold_reset;
    logic tx_off;
    logic lp_req;
    assign hold_reset = rst_pin_low || soft_rst;
    assign tx_off = txd_pin || soft_txd;
    assign lp_req = lp_pin || soft_lp;

    // Module state machine
    mcap_state_type state;
    mcap_state_type next_state;
    logic [TIMER_W-1:0] timer;

    always_comb
    begin
        next_state = state;
        if (hold_reset)
        begin
            next_state = ST_INIT;
        end
        else
        begin
            case (state)
                ST_INIT:
                begin
                    if (timer >= INIT_MAX_CYCLES)
                        next_state = ST_FAULT;
                    else if (init_done && timer >= INIT_MIN_CYCLES - 1'b1)
                        next_state = ST_LOW_POWER;
                end
                ST_LOW_POWER:
                begin
                    if (!lp_req)
                        next_state = ST_HP_UP;
                end
                ST_HP_UP:
                begin
                    if (lp_req)
                        next_state = ST_HP_DOWN;
                    else if (power_up_done)
                        next_state = ST_TX_OFF;
                end
                ST_TX_OFF:
                begin
                    if (lp_req)
                        next_state = ST_HP_DOWN;
                    else if (!tx_off)
                        next_state = ST_TX_TURN_ON;
                end
                ST_TX_TURN_ON:
                begin
                    if (tx_off || lp_req)
                        next_state = ST_TX_TURN_OFF;
                    else if (laser_locked)
                        next_state = ST_READY;
                    else if (timer >= TX_ON_MAX_CYCLES - 1'b1)
                        next_state = ST_FAULT;
                end
                ST_READY:
                begin
                    if (tx_off || lp_req)
                        next_state = ST_TX_TURN_OFF;
                end
                ST_TX_TURN_OFF:
                begin
                    next_state = lp_req ? ST_HP_DOWN : ST_TX_OFF;
                end
                ST_HP_DOWN:
                begin
                    next_state = ST_LOW_POWER;
                end
                ST_FAULT:
                begin
                    next_state = ST_FAULT;
                end
                default:
                begin
                    next_state = ST_FAULT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= ST_INIT;
        else
            state <= next_state;
    end

    // Time spent in the current state; held at zero under module reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            timer <= '0;
        else if (hold_reset || next_state != state)
            timer <= '0;
        else if (timer != '1)
            timer <= timer + 1'b1;
    end

    // Laser enables for every lane move together
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            transmit_enable <= '0;
            low_power_mode <= 1'b1;
        end
        else
        begin
            transmit_enable <= {LANES{(next_state == ST_TX_TURN_ON || next_state == ST_READY)
                && !tx_off && !hold_reset}};
            low_power_mode <= next_state == ST_INIT || next_state == ST_LOW_POWER
                || next_state == ST_FAULT;
        end
    end

    assign module_state = state;

    // Loss of signal qualifier
    mcap_los_if los_bus ();
    assign los_bus.power_low = rx_power_low;

    mcap_los_filter #(
        .MIN_CYCLES(int'(LOSS_MIN_CYC))
    ) u_los (
        .clk(clk),
        .rst_n(rst_n),
        .los(los_bus.filter)
    );

    // Alarm, presence and address pins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            receive_signal_lost <= 1'b0;
            mdio_port_address <= '0;
        end
        else
        begin
            receive_signal_lost <= los_bus.signal_lost;
            mdio_port_address <= addr_sync;
        end
    end

    // Inserted module ties the line low; the host pull-up shows absence
    assign presence_absent_out = 1'b0;

    // Monitor clock divider on the symbol strobe
    logic [4:0] mon_cnt;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mon_cnt <= 5'h00;
            transmit_monitor_clock <= 1'b0;
        end
        else if (!monclk_en)
        begin
            mon_cnt <= 5'h00;
            transmit_monitor_clock <= 1'b0;
        end
        else if (symbol_tick)
        begin
            if (mon_cnt == MON_HALF_M1)
            begin
                mon_cnt <= 5'h00;
                transmit_monitor_clock <= !transmit_monitor_clock;
            end
            else
            begin
                mon_cnt <= mon_cnt + 1'b1;
            end
        end
    end

    // APB: zero wait states; read data and error caught in the setup cycle
    logic addr_ok;
    assign addr_ok = is_addr(paddr, CTRL_OFS) || is_addr(paddr, STATE_OFS) || is_addr(paddr, STATUS_OFS);
    assign pready = 1'b1;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (apb_setup)
        begin
            // Registers stay reachable in every state, low power included
            pslverr <= !addr_ok;
            prdata <= 32'h0000_0000;
            if (!pwrite && is_addr(paddr, CTRL_OFS))
            begin
                prdata[CTRL_SOFT_LP_BIT] <= soft_lp;
                prdata[CTRL_SOFT_TXD_BIT] <= soft_txd;
                prdata[CTRL_MONCLK_EN_BIT] <= monclk_en;
                prdata[CTRL_PIN_TXD_BIT] <= txd_pin;
                prdata[CTRL_PIN_LP_BIT] <= lp_pin;
            end
            else if (!pwrite && is_addr(paddr, STATE_OFS))
            begin
                prdata[8:0] <= state;
            end
            else if (!pwrite && is_addr(paddr, STATUS_OFS))
            begin
                prdata[STAT_LOS_BIT] <= los_bus.signal_lost;
                prdata[STAT_PRESENT_BIT] <= 1'b1;
                prdata[STAT_RST_PIN_BIT] <= rst_pin_low;
                prdata[STAT_ADDR_LSB +: PORT_ADDR_W] <= addr_sync;
            end
        end
        else if (psel && penable)
        begin
            pslverr <= 1'b0;
        end
    end

    // Checks
    sequence seq_init_left;
        state == ST_INIT ##1 state == ST_LOW_POWER;
    endsequence

    sequence seq_off_request;
        tx_off && !hold_reset;
    endsequence

    AST_ONE_HOT: assert property (@(posedge clk) disable iff (!rst_n) $onehot(state))
        else $error("module state not one-hot");

    AST_TX_OFF_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
        seq_off_request |=> transmit_enable == '0)
        else $error("transmitter still on after off request");

    AST_TX_OFF_FROM_PIN: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(transmit_off_request) |-> ##[1:4] transmit_enable == '0)
        else $error("transmitter not off in time");

    AST_TX_ON_STATE: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_TX_TURN_ON || state == ST_READY) && !$past(tx_off) && !$past(hold_reset)
        && $past(state) == state |-> transmit_enable == '1)
        else $error("transmitter not on while enabled");

    AST_LANES_TOGETHER: assert property (@(posedge clk) disable iff (!rst_n)
        transmit_enable == '0 || transmit_enable == '1)
        else $error("lanes disagree");

    AST_TURN_ON_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
        state == ST_TX_TURN_ON |-> timer < TX_ON_MAX_CYCLES)
        else $error("turn-on exceeded its limit");

    AST_LOW_POWER_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        state == ST_LOW_POWER && lp_req && !hold_reset |=> state == ST_LOW_POWER && low_power_mode)
        else $error("left low power while requested");

    AST_LOW_POWER_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
        state == ST_LOW_POWER && !lp_req && !hold_reset |=> state == ST_HP_UP)
        else $error("low power not left on request release");

    AST_RESET_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        hold_reset |=> state == ST_INIT && timer == '0 && transmit_enable == '0)
        else $error("module reset not held");

    AST_INIT_MIN: assert property (@(posedge clk) disable iff (!rst_n)
        seq_init_left |-> $past(timer) >= INIT_MIN_CYCLES - 1'b1)
        else $error("initialization finished too early");

    AST_INIT_MAX: assert property (@(posedge clk) disable iff (!rst_n)
        state == ST_INIT |-> timer <= INIT_MAX_CYCLES)
        else $error("initialization overran");

    AST_MON_DIV: assert property (@(posedge clk) disable iff (!rst_n)
        mon_cnt <= MON_HALF_M1 and ($changed(transmit_monitor_clock) && monclk_en && $past(monclk_en)
        |-> $past(mon_cnt) == MON_HALF_M1 && $past(symbol_tick)))
        else $error("monitor clock divider wrong");

endmodule

// ==== hdl/mcap_pkg.sv ====
// Package for the module control and alarm pin block.
// Assumes a single 200 MHz control clock; all figures are derived here.
package mcap_pkg;

    // Clock rate
    localparam longint unsigned CLK_HZ = 200_000_000;

    // Timing figures as printed, in their own units
    localparam longint unsigned T_OFF_MAX_US = 100;
    localparam longint unsigned T_ON_MAX_S = 25;
    localparam longint unsigned T_INIT_MIN_S = 19;
    localparam longint unsigned T_INIT_MAX_S = 150;
    localparam longint unsigned T_LOSS_MIN_NS = 500;
    localparam longint unsigned T_LOSS_MAX_US = 400;

    // Cycle counts: least times round up, longest times round down
    localparam longint unsigned TX_OFF_MAX_CYC = (T_OFF_MAX_US * CLK_HZ) / 1_000_000;
    localparam longint unsigned TX_ON_MAX_CYC = T_ON_MAX_S * CLK_HZ;
    localparam longint unsigned INIT_MIN_CYC = T_INIT_MIN_S * CLK_HZ;
    localparam longint unsigned INIT_MAX_CYC = T_INIT_MAX_S * CLK_HZ;
    localparam longint unsigned LOSS_MIN_CYC = (T_LOSS_MIN_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
    localparam longint unsigned LOSS_MAX_CYC = (T_LOSS_MAX_US * CLK_HZ) / 1_000_000;

    // Wide enough for the longest count
    localparam int TIMER_W = 36;

    // Monitor clock: one period per 48 symbols, toggled every 24
    localparam int MON_DIV = 48;
    localparam logic [4:0] MON_HALF_M1 = 5'h17;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATE_OFS = 12'h004;
    localparam logic [11:0] STATUS_OFS = 12'h008;

    // Control register fields
    localparam int CTRL_SOFT_RST_BIT = 15;
    localparam int CTRL_SOFT_LP_BIT = 14;
    localparam int CTRL_SOFT_TXD_BIT = 13;
    localparam int CTRL_MONCLK_EN_BIT = 12;
    localparam int CTRL_PIN_TXD_BIT = 5;
    localparam int CTRL_PIN_LP_BIT = 4;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Status register fields
    localparam int STAT_LOS_BIT = 0;
    localparam int STAT_PRESENT_BIT = 1;
    localparam int STAT_RST_PIN_BIT = 2;
    localparam int STAT_ADDR_LSB = 8;

    // Module states, one bit each
    typedef enum logic [8:0] {
        ST_INIT = 9'h001,
        ST_LOW_POWER = 9'h002,
        ST_HP_UP = 9'h004,
        ST_TX_OFF = 9'h008,
        ST_TX_TURN_ON = 9'h010,
        ST_READY = 9'h020,
        ST_FAULT = 9'h040,
        ST_TX_TURN_OFF = 9'h080,
        ST_HP_DOWN = 9'h100
    } mcap_state_type;

endpackage

// ==== hdl/mcap_los_if.sv ====
// Carries the raw low-light level to the loss qualifier and its result back.
// Assumes both ends share the control clock.
`timescale 1ns/10ps
interface mcap_los_if;
    logic power_low;
    logic signal_lost;
    modport filter (input power_low, output signal_lost);
    modport user (output power_low, input signal_lost);
endinterface

// ==== hdl/mcap_los_filter.sv ====
// Qualifies the received low-power indication into the signal-lost alarm.
// Assumes the raw level is already synchronous to clk.
`timescale 1ns/10ps
module mcap_los_filter
    import mcap_pkg::*;
#(
    parameter int MIN_CYCLES = int'(LOSS_MIN_CYC)
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Alarm path
    mcap_los_if.filter los
);

    localparam int CNT_W = $clog2(MIN_CYCLES + 1);

    if (MIN_CYCLES < 1 || longint'(MIN_CYCLES) > LOSS_MAX_CYC)
    begin : g_bad_min
        $error("mcap_los_filter: MIN_CYCLES out of range");
    end

    logic [CNT_W-1:0] cnt;
    logic lost;

    // A change must persist for the full minimum before the alarm follows it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            lost <= 1'b0;
        end
        else if (los.power_low == lost)
        begin
            cnt <= '0;
        end
        else if (cnt == CNT_W'(MIN_CYCLES - 1))
        begin
            cnt <= '0;
            lost <= los.power_low;
        end
        else
        begin
            cnt <= cnt + 1'b1;
        end
    end

    assign los.signal_lost = lost;

    AST_LOS_NOT_EARLY: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(lost) |-> $past(cnt) == CNT_W'(MIN_CYCLES - 1) && $past(los.power_low) == lost)
        else $error("signal lost changed before its minimum time");

    AST_LOS_BOUNDED: assert property (@(posedge clk) disable iff (!rst_n)
        cnt < CNT_W'(MIN_CYCLES) and (cnt != '0 |-> $past(los.power_low) != $past(lost)))
        else $error("signal lost qualifier counting out of bounds");

endmodule

// ==== verification/mcap_host_model.sv ====
// Host board model: drives the control and address pins, reads presence.
// Assumes the bench sets wanted levels; pins move just after clk rises.
`timescale 1ns/10ps
module mcap_host_model
    import mcap_pkg::*;
(
    // Clock
    input wire logic clk,
    // Wanted levels
    input wire logic want_tx_off,
    input wire logic want_low_power,
    input wire logic want_reset,
    input wire logic [4:0] want_addr,
    // Pins to the module
    output logic transmit_off_request = 1'b0,
    output logic low_power_request = 1'b1,
    output logic module_reset_low = 1'b1,
    output logic [4:0] port_address_pins = 5'h00,
    // Presence through the host pull-up
    input wire logic presence_absent_out,
    output logic module_seen
);
    always @(posedge clk)
    begin
        transmit_off_request <= want_tx_off;
        low_power_request <= want_low_power;
        module_reset_low <= !want_reset;
        port_address_pins <= want_addr;
    end
    // Pull-up wins unless the module pulls down
    assign module_seen = (presence_absent_out === 1'b0);
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the control and alarm pin block.
// Assumes shortened init and laser timers; pins reach it through the host model.
`timescale 1ns/10ps
module tb_top
    import mcap_pkg::*;
;
    logic clk = 0;
    logic reset_n = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err;
    logic want_tx = 0, want_lp = 1, want_rst = 0;
    logic [4:0] want_addr = 5'h00, addr_pin, mdio_addr;
    logic tx_pin, lp_pin, rst_pin, seen, los, absent, mon, lp_mode;
    logic init_done = 0, up_done = 0, locked = 0, rx_low = 0, tick = 0, mon_prev = 0;
    logic [3:0] tx_en;
    logic [8:0] module_state;
    int bad_count = 0, comparisons = 0, cyc = 0, n = 0, toggles = 0;

    mcap_host_model host (.clk(clk), .want_tx_off(want_tx), .want_low_power(want_lp),
        .want_reset(want_rst), .want_addr(want_addr), .transmit_off_request(tx_pin),
        .low_power_request(lp_pin), .module_reset_low(rst_pin), .port_address_pins(addr_pin),
        .presence_absent_out(absent), .module_seen(seen));

    mcap_top #(.INIT_MIN_CYCLES(TIMER_W'(50)), .INIT_MAX_CYCLES(TIMER_W'(200)),
        .TX_ON_MAX_CYCLES(TIMER_W'(100)), .TX_OFF_MAX_CYCLES(TIMER_W'(10))) dut (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .transmit_off_request(tx_pin), .low_power_request(lp_pin), .module_reset_low(rst_pin),
        .port_address_pins(addr_pin), .init_done(init_done), .power_up_done(up_done),
        .laser_locked(locked), .rx_power_low(rx_low), .symbol_tick(tick),
        .receive_signal_lost(los), .presence_absent_out(absent), .transmit_monitor_clock(mon),
        .transmit_enable(tx_en), .low_power_mode(lp_mode), .mdio_port_address(mdio_addr),
        .module_state(module_state));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
        comparisons++;
        if (seen_v !== exp_v)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp_v, seen_v);
        end
    endtask

    function automatic logic [31:0] ctrl_word(input logic lp, input logic txd);
        ctrl_word = '0;
        ctrl_word[CTRL_SOFT_LP_BIT] = lp;
        ctrl_word[CTRL_SOFT_TXD_BIT] = txd;
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic drive(input logic tx, input logic lp, input logic rst);
        @(posedge clk);
        want_tx <= tx;
        want_lp <= lp;
        want_rst <= rst;
    endtask

    task automatic wait_state(input logic [8:0] s, input int lim);
        n = 0;
        while (module_state !== s && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= lim)
            bad_count++;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 95000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    always @(negedge clk)
    begin
        if (mon !== mon_prev)
            toggles++;
        mon_prev = mon;
        if (reset_n === 1'b1)
            chk("one hot", $countones(module_state), 1);
    end

    initial
    begin
        void'($urandom(94));
        repeat (12) @(posedge clk);
        reset_n <= 1;
        repeat (3) @(negedge clk);
        chk("start state", module_state, ST_INIT);
        // Init never reports done, so the block must give up
        wait_state(ST_FAULT, 400);
        chk("fault time", n >= 190 && n <= 215, 1);
        drive(0, 1, 1);
        init_done <= 1;
        repeat (6) @(negedge clk);
        chk("reset hold", module_state, ST_INIT);
        chk("lasers off", tx_en, 4'h0);
        apb(0, STATUS_OFS, '0);
        chk("reset pin bit", rd[STAT_RST_PIN_BIT], 1);
        drive(0, 1, 0);
        wait_state(ST_LOW_POWER, 300);
        chk("init time", n >= 50 && n <= 205, 1);
        repeat (30) @(negedge clk);
        apb(0, STATE_OFS, '0);
        chk("stay low power", rd, 32'h0000_0002);
        chk("lp mode", lp_mode, 1);
        @(posedge clk);
        up_done <= 1;
        drive(1, 0, 0);
        wait_state(ST_TX_OFF, 100);
        repeat (20) @(negedge clk);
        chk("held off", module_state, ST_TX_OFF);
        chk("tx off", tx_en, 4'h0);
        drive(0, 0, 0);
        wait_state(ST_TX_TURN_ON, 20);
        chk("all lanes on", tx_en, 4'hf);
        @(posedge clk);
        locked <= 1;
        wait_state(ST_READY, 20);
        chk("ready", module_state, ST_READY);
        repeat (4)
        begin
            drive(1, 0, 0);
            n = 0;
            while (tx_en !== 4'h0 && n < 50)
            begin
                @(negedge clk);
                n++;
            end
            chk("off time", n <= 11, 1);
            repeat (5 + $urandom % 30) @(posedge clk);
            drive(0, 0, 0);
            wait_state(ST_READY, 150);
            chk("on time", n <= 101, 1);
            chk("on again", tx_en, 4'hf);
        end
        apb(1, CTRL_OFS, 32'h0000_2000);
        repeat (4) @(negedge clk);
        chk("soft off", tx_en, 4'h0);
        apb(0, CTRL_OFS, '0);
        chk("ctrl read", rd, ctrl_word(0, 1));
        apb(0, 12'h00c, '0);
        chk("unmapped err", err, 1);
        chk("unmapped data", rd, 0);
        apb(1, CTRL_OFS, 32'h0000_1000);
        wait_state(ST_READY, 150);
        toggles = 0;
        repeat (96)
        begin
            @(posedge clk);
            tick <= 1;
            @(posedge clk);
            tick <= 0;
            repeat ($urandom % 3) @(posedge clk);
        end
        repeat (4) @(negedge clk);
        chk("monitor toggles", toggles, 4);
        // Short dips must not raise the alarm
        repeat (6)
        begin
            @(posedge clk);
            rx_low <= 1;
            repeat (1 + $urandom % 90) @(posedge clk);
            rx_low <= 0;
            repeat (10) @(negedge clk);
            chk("glitch ignored", los, 0);
        end
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge clk);
            rx_low <= v[0];
            n = 0;
            while (los !== v[0] && n < 80010)
            begin
                @(negedge clk);
                n++;
            end
            chk("loss time", n >= 100 && n <= 80000, 1);
            apb(0, STATUS_OFS, '0);
            chk("loss status", rd[STAT_LOS_BIT], v[0]);
        end
        repeat (4)
        begin
            @(posedge clk);
            want_addr <= 5'($urandom);
            repeat (8) @(negedge clk);
            chk("mdio addr", mdio_addr, want_addr);
            apb(0, STATUS_OFS, '0);
            chk("addr status", rd[12:8], want_addr);
        end
        chk("present", seen, 1);
        drive(0, 1, 0);
        wait_state(ST_LOW_POWER, 200);
        chk("back to low power", tx_en, 4'h0);
        chk("lp mode again", lp_mode, 1);
        // Soft reset and soft low power in one write
        apb(1, CTRL_OFS, 32'h0000_c000);
        repeat (2) @(negedge clk);
        chk("soft reset", module_state, ST_INIT);
        drive(0, 0, 0);
        wait_state(ST_LOW_POWER, 200);
        repeat (10) @(negedge clk);
        chk("soft low power", module_state, ST_LOW_POWER);
        apb(0, CTRL_OFS, '0);
        chk("ctrl lp read", rd, ctrl_word(1, 0));
        report_and_stop();
    end
endmodule
